/* File: rcg_defines.svh */
// Register offsets, field positions, reset values and bus timing for the
// reference clock generator.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef RCG_DEFINES_SVH
`define RCG_DEFINES_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define RCG_CTRL_ADDR   12'h000
`define RCG_TRIM_ADDR   12'h004

// ************************************************************
// Control register fields
// ************************************************************
`define RCG_DIV_HI      30
`define RCG_DIV_LO      16
`define RCG_ON_BIT      15
`define RCG_STOP_IN_IDLE_BIT    13
`define RCG_OE_BIT      12
`define RCG_RUN_IN_SLEEP_BIT    11
`define RCG_SWEN_BIT    9
`define RCG_ACTIVE_BIT  8
`define RCG_SEL_HI      3
`define RCG_SEL_LO      0

// ************************************************************
// Trim register fields
// ************************************************************
`define RCG_TRIM_HI     31
`define RCG_TRIM_LO     23

// ************************************************************
// Reset values and timing
// ************************************************************
`define RCG_CTRL_RESET  32'h0000_0000
`define RCG_TRIM_RESET  32'h0000_0000
`define RCG_APB_WAITS   1

`endif

/* File: rcg_pkg.sv */
// Types shared by the reference clock generator modules.
// Assumes rcg_defines.svh is compiled alongside.
package rcg_pkg;

	// ************************************************************
	// Source select codes
	// ************************************************************
	typedef enum logic [3:0] {
		RCG_SRC_SYSTEM   = 4'b0000,
		RCG_SRC_PBUS     = 4'b0001,
		RCG_SRC_PRIMARY  = 4'b0010,
		RCG_SRC_FAST_RC  = 4'b0011,
		RCG_SRC_LOW_RC   = 4'b0100,
		RCG_SRC_SECOND   = 4'b0101,
		RCG_SRC_USB_PLL  = 4'b0110,
		RCG_SRC_SYS_PLL  = 4'b0111,
		RCG_SRC_EXT_PIN  = 4'b1000
	} rcg_src_t;

	// ************************************************************
	// Switch handshake states
	// ************************************************************
	typedef enum logic [0:0] {
		RCG_SW_IDLE = 1'b0,
		RCG_SW_PEND = 1'b1
	} rcg_sw_state_t;

	// ************************************************************
	// Divider configuration carried as one unit
	// ************************************************************
	typedef struct packed {
		logic [14:0] div;
		logic [8:0]  trim;
		logic [3:0]  sel;
	} rcg_cfg_t;

endpackage

/* File: rcg_src_select.sv */
// Source clock selector: synchronises the external source clocks and
// reports rising edges and the level of the selected one.
// Assumes the sources are well below half the pclk rate.
`timescale 1ns/100ps
module rcg_src_select
	import rcg_pkg::*;
#(
	parameter int NUM_EXT = 8
)(
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// Source clocks for codes 0001 upward
	input  wire logic [NUM_EXT-1:0] ext_clk_in,
	// Selection
	input  wire logic [3:0]         sel,
	// Selected source
	output logic                    src_edge,
	output logic                    src_level
);

	// ************************************************************
	// Synchronisers
	// ************************************************************
	logic [NUM_EXT-1:0] sync1_reg;  // First stage, read by stage two only
	logic [NUM_EXT-1:0] sync2_reg;  // Usable level
	logic [NUM_EXT-1:0] sync3_reg;  // Delayed level for edge detect
	logic               tog_reg;    // System clock stand-in level

	genvar g;
	generate
		for (g = 0; g < NUM_EXT; g++) begin : g_sync
			// Two flops before any logic looks at the pin
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync1_reg[g] <= 1'b0;
					sync2_reg[g] <= 1'b0;
					sync3_reg[g] <= 1'b0;
				end else begin
					sync1_reg[g] <= ext_clk_in[g];
					sync2_reg[g] <= sync1_reg[g];
					sync3_reg[g] <= sync2_reg[g];
				end
			end
		end
	endgenerate

	// System clock is pclk itself: one edge per cycle, level toggles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tog_reg <= 1'b0;
		end else begin
			tog_reg <= ~tog_reg;
		end
	end

	// ************************************************************
	// Selection; reserved codes give no edges
	// ************************************************************
	wire       sel_ext = (sel != RCG_SRC_SYSTEM) && (sel <= RCG_SRC_EXT_PIN);
	wire [3:0] ext_idx = sel - 4'h1;
	wire [2:0] bit_idx = ext_idx[2:0];
	wire       ext_lvl = sync2_reg[bit_idx];
	wire       ext_edg = sync2_reg[bit_idx] & ~sync3_reg[bit_idx];

	assign src_edge  = (sel == RCG_SRC_SYSTEM) ? 1'b1
		: (sel_ext ? ext_edg : 1'b0);
	assign src_level = (sel == RCG_SRC_SYSTEM) ? tog_reg
		: (sel_ext ? ext_lvl : 1'b0);

	// ************************************************************
	// Checks
	// ************************************************************
	reserved_quiet_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(sel > RCG_SRC_EXT_PIN) |-> (!src_edge && !src_level))
		else $error("Reserved source code produced an edge");

endmodule

/* File: rcg_divider.sv */
// Fractional divider: half period of div source edges plus one extra
// edge whenever the trim accumulator overflows 512.
// Assumes cfg changes only in the cycle that load_done is high.
`timescale 1ns/100ps
module rcg_divider
	import rcg_pkg::*;
(
	// Clock and reset
	input  wire logic     pclk,
	input  wire logic     presetn,
	// Control
	input  wire logic     run,
	input  wire rcg_cfg_t cfg,
	input  wire logic     load_req,
	// Source
	input  wire logic     src_edge,
	input  wire logic     src_level,
	// Result
	output logic          clk_out,
	output logic          load_done
);

	// ************************************************************
	// State
	// ************************************************************
	logic [14:0] cnt_reg;    // Source edges in this half period
	logic [8:0]  acc_reg;    // Trim accumulator
	logic        extra_reg;  // Stretch this half period by one edge
	logic        clk_reg;    // Generated clock

	// ************************************************************
	// Half period decode
	// ************************************************************
	wire        pass     = (cfg.div == 15'h0000);
	wire [15:0] target   = {1'b0, cfg.div} + {15'h0000, extra_reg};
	wire [15:0] cnt_inc  = {1'b0, cnt_reg} + 16'h0001;
	wire        half_end = run && !pass && src_edge && (cnt_inc >= target);
	wire [9:0]  acc_sum  = {1'b0, acc_reg} + {1'b0, cfg.trim};
	// Switch only when stopped or as a high half period ends (undivided: while the source is low), so no runt pulse escapes
	wire        boundary = !run
		|| (pass ? !src_level : (half_end && clk_reg));

	assign load_done = load_req && boundary;
	assign clk_out   = clk_reg;

	// Divider counters and output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg   <= 15'h0000;
			acc_reg   <= 9'h000;
			extra_reg <= 1'b0;
			clk_reg   <= 1'b0;
		end else if (!run) begin
			// Stopped: output low, restart cleanly
			cnt_reg   <= 15'h0000;
			acc_reg   <= 9'h000;
			extra_reg <= 1'b0;
			clk_reg   <= 1'b0;
		end else if (pass) begin
			// Undivided: follow the source
			cnt_reg   <= 15'h0000;
			acc_reg   <= 9'h000;
			extra_reg <= 1'b0;
			clk_reg   <= src_level;
		end else if (load_done) begin
			// Falling boundary with new settings
			cnt_reg   <= 15'h0000;
			acc_reg   <= 9'h000;
			extra_reg <= 1'b0;
			clk_reg   <= 1'b0;
		end else if (half_end) begin
			cnt_reg   <= 15'h0000;
			acc_reg   <= acc_sum[8:0];
			extra_reg <= acc_sum[9];
			clk_reg   <= ~clk_reg;
		end else if (src_edge) begin
			cnt_reg   <= cnt_inc[14:0];
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	toggle_count_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(run && $past(run) && !pass && !load_req && $changed(clk_reg)
		 && cfg.trim == 9'h000 && $stable(cfg))
		|-> ($past(cnt_reg) == cfg.div - 15'h0001))
		else $error("Half period differs from the divider value");

endmodule

/* File: rcg_top.sv */
// Reference clock generator: APB registers, switch handshake, power
// mode gating and output pin drive around the selector and divider.
// Assumes the power controller and APB master share pclk; source clock
// pins are asynchronous and are synchronised inside the selector.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "rcg_defines.svh"
module rcg_top
	import rcg_pkg::*;
#(
	parameter int NUM_EXT = 8
)(
	// APB clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Power mode inputs, same clock domain
	input  wire logic               wait_executed,
	input  wire logic               sleep_on_wait_select,
	// Source clocks, codes 0001 to 1000 in order
	input  wire logic [NUM_EXT-1:0] ext_clk_in,
	// Reference clock outputs
	output logic                    ref_clock_out_pin,
	output logic                    ref_clock_out_oe_n,
	output logic                    ref_clock_internal
);

	// ************************************************************
	// Address decode
	// ************************************************************
	// Shared decode of one register address
	function automatic logic addr_hit(input logic [11:0] a,
		input logic [11:0] reg_addr);
		addr_hit = (a[11:2] == reg_addr[11:2]);
	endfunction

	wire setup_ph = psel && !penable;              // APB setup cycle
	wire access   = psel && penable && pready;     // Transfer completes
	wire hit_ctrl = addr_hit(paddr, `RCG_CTRL_ADDR);
	wire hit_trim = addr_hit(paddr, `RCG_TRIM_ADDR);
	wire ctrl_wr  = access && pwrite && hit_ctrl;
	wire trim_wr  = access && pwrite && hit_trim;
	wire swen_set = ctrl_wr && pwdata[`RCG_SWEN_BIT];

	// ************************************************************
	// Software-visible registers
	// ************************************************************
	logic          on_reg;      // Module enable
	logic          stop_in_idle_reg;    // Stop in idle
	logic          oe_reg;      // Drive pin
	logic          run_in_sleep_reg;    // Run in sleep
	logic          swen_reg;    // Switch in progress
	logic          active_reg;  // Clock request status
	logic [14:0]   div_reg;     // Written divider value
	logic [3:0]    sel_reg;     // Written source code
	logic [8:0]    trim_reg;    // Written trim value
	rcg_cfg_t      act_reg;     // Settings in use by the divider
	rcg_sw_state_t sw_state_reg;
	rcg_sw_state_t sw_state_next;

	// ************************************************************
	// Power mode decode
	// ************************************************************
	wire sleep_mode = wait_executed && sleep_on_wait_select;
	wire idle_mode  = wait_executed && !sleep_on_wait_select;
	// System and bus clocks die in sleep, so run-in-sleep is moot there
	wire sel_core   = (act_reg.sel == RCG_SRC_SYSTEM)
		|| (act_reg.sel == RCG_SRC_PBUS);
	wire sleep_ok   = run_in_sleep_reg && !sel_core;
	wire run        = on_reg
		&& !(idle_mode && stop_in_idle_reg)
		&& !(sleep_mode && !sleep_ok);

	// ************************************************************
	// Submodules
	// ************************************************************
	wire      src_edge;
	wire      src_level;
	wire      div_clk;
	wire      load_done;
	wire      load_req = (sw_state_reg == RCG_SW_PEND);
	rcg_cfg_t shadow;

	assign shadow = '{div: div_reg, trim: trim_reg, sel: sel_reg};

	rcg_src_select #(
		.NUM_EXT    (NUM_EXT)
	) u_src (
		.pclk       (pclk),
		.presetn    (presetn),
		.ext_clk_in (ext_clk_in),
		.sel        (act_reg.sel),
		.src_edge   (src_edge),
		.src_level  (src_level)
	);

	rcg_divider u_div (
		.pclk      (pclk),
		.presetn   (presetn),
		.run       (run),
		.cfg       (act_reg),
		.load_req  (load_req),
		.src_edge  (src_edge),
		.src_level (src_level),
		.clk_out   (div_clk),
		.load_done (load_done)
	);

	// ************************************************************
	// Switch handshake
	// ************************************************************
	// A set landing on the completing cycle starts a fresh switch
	always_comb begin
		sw_state_next = sw_state_reg;
		case (sw_state_reg)
			RCG_SW_IDLE: begin
				if (swen_set) begin
					sw_state_next = RCG_SW_PEND;
				end
			end
			RCG_SW_PEND: begin
				if (load_done && !swen_set) begin
					sw_state_next = RCG_SW_IDLE;
				end
			end
			default: begin
				sw_state_next = RCG_SW_IDLE;
			end
		endcase
	end

	// State and switch flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_state_reg <= RCG_SW_IDLE;
			swen_reg     <= 1'b0;
		end else begin
			sw_state_reg <= sw_state_next;
			swen_reg     <= (sw_state_next == RCG_SW_PEND);
		end
	end

	// Settings in use: follow writes while off, else only on a switch.
	// Changing them while the request is active is left to software.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_reg <= '0;
		end else if (!on_reg || load_done) begin
			act_reg <= shadow;
		end
	end

	// ************************************************************
	// Register writes
	// ************************************************************
	// Control register fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_reg   <= 1'(`RCG_CTRL_RESET >> `RCG_ON_BIT);
			stop_in_idle_reg <= 1'b0;
			oe_reg   <= 1'b0;
			run_in_sleep_reg <= 1'b0;
			div_reg  <= 15'h0000;
			sel_reg  <= 4'h0;
		end else if (ctrl_wr) begin
			on_reg   <= pwdata[`RCG_ON_BIT];
			stop_in_idle_reg <= pwdata[`RCG_STOP_IN_IDLE_BIT];
			oe_reg   <= pwdata[`RCG_OE_BIT];
			run_in_sleep_reg <= pwdata[`RCG_RUN_IN_SLEEP_BIT];
			div_reg  <= pwdata[`RCG_DIV_HI:`RCG_DIV_LO];
			sel_reg  <= pwdata[`RCG_SEL_HI:`RCG_SEL_LO];
		end
	end

	// Trim register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim_reg <= 9'h000;
		end else if (trim_wr) begin
			trim_reg <= pwdata[`RCG_TRIM_HI:`RCG_TRIM_LO];
		end
	end

	// ************************************************************
	// Read data and APB answer
	// ************************************************************
	wire [31:0] ctrl_rd = {1'b0, div_reg, on_reg, 1'b0, stop_in_idle_reg,
		oe_reg, run_in_sleep_reg, 1'b0, swen_reg, active_reg, 4'h0,
		sel_reg};
	wire [31:0] trim_rd = {trim_reg, 23'h00_0000};
	wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd
		: (hit_trim ? trim_rd : 32'h0000_0000);
	wire        bad_adr = !hit_ctrl && !hit_trim;

	// One wait-free access: answer prepared during setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph && bad_adr;
			prdata  <= (setup_ph && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// ************************************************************
	// Status and outputs
	// ************************************************************
	// Request status mirrors the run condition; pin gated by drive bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_reg         <= 1'b0;
			ref_clock_out_pin  <= 1'b0;
			ref_clock_out_oe_n <= 1'b1;
			ref_clock_internal <= 1'b0;
		end else begin
			active_reg         <= run;
			ref_clock_out_pin  <= div_clk && oe_reg;
			ref_clock_out_oe_n <= !oe_reg;
			ref_clock_internal <= div_clk;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	off_quiet_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!on_reg ##1 !on_reg |=> !ref_clock_internal)
		else $error("Reference clock runs while disabled");

	idle_stop_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(idle_mode && stop_in_idle_reg) |=> !div_clk ##1 !ref_clock_internal)
		else $error("Generator not halted in Idle");

	pin_gate_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!oe_reg |=> (!ref_clock_out_pin && ref_clock_out_oe_n))
		else $error("Pin driven while drive bit clear");

	sleep_gate_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(sleep_mode && !run_in_sleep_reg) |=> !div_clk)
		else $error("Output runs in Sleep without run-in-sleep");

	sleep_core_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(sleep_mode && sel_core) |=> !div_clk)
		else $error("Core clock source kept running in Sleep");

	pend_hold_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(on_reg && ctrl_wr && pwdata[`RCG_ON_BIT] && !swen_set
		 && !load_req) |=> $stable(act_reg))
		else $error("Divider or source applied without switch");

	trim_hold_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(on_reg && trim_wr && !load_req && !swen_set)
		|=> (act_reg.trim == $past(act_reg.trim)))
		else $error("Trim applied without switch");

	swen_clear_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(load_done && !swen_set) |=> (!swen_reg && !load_req))
		else $error("Switch flag not cleared after switch");

	swen_set_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(swen_set && on_reg && run && !load_done) |=> swen_reg)
		else $error("Switch flag lost on set");

	active_mirror_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		run |=> active_reg)
		else $error("Request status does not follow run");

	ctrl_zero_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(setup_ph && !pwrite && hit_ctrl) |=>
		(prdata[7:4] == 4'h0 && !prdata[10] && !prdata[14] && !prdata[31]))
		else $error("Unimplemented control bits read nonzero");

	trim_read_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(setup_ph && !pwrite && hit_trim) |=>
		(prdata == {$past(trim_reg), 23'h00_0000}))
		else $error("Trim read does not show trim value");

	switch_cov: cover property (
		@(posedge pclk) disable iff (!presetn)
		swen_set ##[1:200] load_done);

	pin_cov: cover property (
		@(posedge pclk) disable iff (!presetn)
		oe_reg && $rose(ref_clock_out_pin));

	sleep_cov: cover property (
		@(posedge pclk) disable iff (!presetn)
		sleep_mode && sleep_ok && $rose(div_clk));

endmodule

/* File: rcg_sink_model.sv */
// Far-side model: drives the source clock pins and times the reference
// clock pin as a receiver would.
// Assumes pclk runs at 10 MHz; the sources toggle 30 ns after a pclk rising edge.
`timescale 1ns/100ps
module rcg_sink_model (
	// Clock
	input  wire logic        pclk,
	// Source clocks, bit k has a half period of k+2 cycles
	output logic [7:0]       ext_clk_in,
	// Received clock and its last measured period in cycles
	input  wire logic        ref_clock_out_pin,
	output logic [15:0]      period
);
	logic [15:0] cnt_reg;  // Cycles since the last rising edge
	logic        last_reg; // Pin level one cycle ago
	wire         rise = ref_clock_out_pin && !last_reg;
	initial begin
		ext_clk_in = 8'h00;
		cnt_reg = 16'h0000;
		last_reg = 1'b0;
		period = 16'h0000;
	end
	// Toggle well away from pclk so the synchroniser sees clean edges
	for (genvar k = 0; k < 8; k++) begin : g_src
		initial forever begin
			repeat (k + 2) @(posedge pclk);
			#30 ext_clk_in[k] = ~ext_clk_in[k];
		end
	end
	// Rising edge to rising edge period of the pin
	always @(posedge pclk) begin
		last_reg <= ref_clock_out_pin;
		cnt_reg <= rise ? 16'h0001 : cnt_reg + 16'h0001;
		if (rise) begin
			period <= cnt_reg;
		end
	end
endmodule

/* File: rcg_top_test.sv */
// Self-checking bench: APB master, power-mode stimulus and period checks.
// Assumes the sink model drives the source clocks.
`timescale 1ns/100ps
`include "rcg_defines.svh"
module rcg_top_test
	import rcg_pkg::*;
;
	// ************************************************************
	// Signals
	// ************************************************************
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        wait_executed, sleep_on_wait_select;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_data, w;
	logic [31:0] cur;       // Last control word written
	logic [7:0]  ext_clk_in;
	logic        ref_clock_out_pin, ref_clock_out_oe_n, ref_clock_internal;
	logic [15:0] period;
	logic [32:0] exp_q[$]; // Expected {pslverr, prdata} per read
	logic        seen_pin;  // Pin ever high while not driven
	logic        seen_int;  // Internal clock ever high
	int          bad_count, samples_checked, seed, i;
	localparam logic [11:0] ctrl_a = `RCG_CTRL_ADDR;
	localparam logic [11:0] trim_a = `RCG_TRIM_ADDR;
	rcg_top #(.NUM_EXT(8)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wait_executed(wait_executed),
		.sleep_on_wait_select(sleep_on_wait_select),
		.ext_clk_in(ext_clk_in), .ref_clock_out_pin(ref_clock_out_pin),
		.ref_clock_out_oe_n(ref_clock_out_oe_n),
		.ref_clock_internal(ref_clock_internal));
	rcg_sink_model sink_u (.pclk(pclk), .ext_clk_in(ext_clk_in),
		.ref_clock_out_pin(ref_clock_out_pin), .period(period));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		samples_checked++;
		if (seen !== want) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic conclude();
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One APB transfer; holds everything until pready is seen high
	task automatic xfer(input logic wr, input logic [11:0] a,
			input logic [31:0] d);
		if (wr && a == ctrl_a)
			cur = d;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No local limit: only the watchdog ends a hung wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd_data = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] want);
		exp_q.push_back(want);
		xfer(1'b0, a, 32'h0000_0000);
	endtask
	task automatic per(input int cyc, input logic [15:0] want);
		repeat (cyc) @(posedge pclk);
		check({17'h0_0000, period}, {17'h0_0000, want});
	endtask
	// Program with the generator stopped so values go live at once
	task automatic setup(input logic [14:0] dv, input logic [8:0] tr,
			input logic [3:0] sl, input logic [15:0] want);
		// Stop first with fields unchanged, so none moves while active
		xfer(1'b1, ctrl_a, cur & 32'hFFFF_7FFF);
		xfer(1'b1, ctrl_a, {1'b0, dv, 12'h000, sl});
		xfer(1'b1, trim_a, {tr, 23'h00_0000});
		xfer(1'b1, ctrl_a, {1'b0, dv, 12'h900, sl});
		per(4 * want + 20, want);
	endtask
	// Read watcher: oldest note against each completed read
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
			check({pslverr, prdata}, exp_q.pop_front());
	initial begin
		repeat (30000) @(posedge pclk);
		bad_count++;
		conclude();
	end
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{presetn, psel, penable, pwrite, wait_executed} = 5'h00;
		{sleep_on_wait_select, paddr, pwdata} = 45'h0;
		bad_count = 0;
		samples_checked = 0;
		seed = 27858;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(ctrl_a, 33'h0_0000_0000);
		rd(trim_a, 33'h0_0000_0000);
		w = $random(seed);
		xfer(1'b1, trim_a, w);
		rd(trim_a, {1'b0, w & 32'hFF80_0000});
		xfer(1'b1, ctrl_a, 32'hFFFF_45F2);
		rd(ctrl_a, 33'h0_7FFF_0002);
		rd(12'h008, 33'h1_0000_0000);
		setup(15'd2, 9'd256, 4'h0, 16'd5);
		setup(15'd0, 9'd0, 4'h3, 16'd8);
		setup(15'd3, 9'd0, 4'h0, 16'd6);
		xfer(1'b1, trim_a, 32'h8000_0000);
		wait_executed <= 1'b1;
		xfer(1'b1, ctrl_a, 32'h0003_B000);
		xfer(1'b1, ctrl_a, 32'h0005_B000);
		rd(ctrl_a, 33'h0_0005_B000);
		wait_executed <= 1'b0;
		per(40, 16'd6);
		xfer(1'b1, ctrl_a, 32'h0005_B200);
		for (i = 0; i < 40 && (i == 0 || rd_data[9] !== 1'b0); i++)
			xfer(1'b0, ctrl_a, 32'h0000_0000);
		rd(ctrl_a, 33'h0_0005_B100);
		per(60, 16'd11);
		xfer(1'b1, ctrl_a, 32'h0005_B800);
		{wait_executed, sleep_on_wait_select} <= 2'b11;
		rd(ctrl_a, 33'h0_0005_B800);
		{wait_executed, sleep_on_wait_select} <= 2'b00;
		for (i = 0; i < 9; i++)
			setup(15'd1, 9'd0, 4'(i), 16'(i == 0 ? 2 : 4 * i + 4));
		xfer(1'b1, ctrl_a, 32'h0001_B808);
		{wait_executed, sleep_on_wait_select} <= 2'b11;
		rd(ctrl_a, 33'h0_0001_B908);
		sleep_on_wait_select <= 1'b0;
		rd(ctrl_a, 33'h0_0001_B808);
		sleep_on_wait_select <= 1'b1;
		xfer(1'b1, ctrl_a, 32'h0001_B008);
		rd(ctrl_a, 33'h0_0001_B008);
		wait_executed <= 1'b0;
		check({32'h0, ref_clock_out_oe_n}, 33'h0_0000_0000);
		xfer(1'b1, ctrl_a, 32'h0001_8008);
		// Pin launched at the write edge still carries the old gate
		@(posedge pclk);
		{seen_pin, seen_int} = 2'b00;
		repeat (60) @(posedge pclk) begin
			seen_pin |= ref_clock_out_pin;
			seen_int |= ref_clock_internal;
		end
		w = {29'h0000_0000, seen_int, seen_pin, ref_clock_out_oe_n};
		check({1'b0, w}, 33'h0_0000_0005);
		// Reserved source code, set while stopped
		xfer(1'b1, ctrl_a, 32'h0001_0008);
		xfer(1'b1, ctrl_a, 32'h0001_000F);
		rd(ctrl_a, 33'h0_0001_000F);
		conclude();
	end
endmodule
